// >>> design/uart_flag_pkg.sv
// shared constants and types for the serial port control and flag logic
package uart_flag_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RXDATA = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_ADDR   = 8'h10;

	// field positions
	localparam int unsigned CTRL_LSB       = 3;
	localparam int unsigned CTRL_MSB       = 7;
	localparam int unsigned RX9_POS        = 2;
	localparam int unsigned FLAG_MSB       = 1;
	localparam int unsigned PORT_ADDR_LSB  = 0;
	localparam int unsigned BCAST_ADDR_LSB = 8;

	// reset values
	localparam logic [4:0] CTRL_RST       = 5'h00;
	localparam logic [1:0] MASK_RST       = 2'h0;
	localparam logic [7:0] PORT_ADDR_RST  = 8'h00;
	localparam logic [7:0] BCAST_ADDR_RST = 8'hff;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MODE_SYNC = 2'h0,
		MODE_8BIT = 2'h1,
		MODE_9FIX = 2'h2,
		MODE_9VAR = 2'h3
	} serial_mode_t;

	// layout matches control register bits 7..3
	typedef struct packed {
		serial_mode_t mode;
		logic         multiproc_stop_check;
		logic         rx_enable_bit;
		logic         tx_ninth_bit;
	} ctrl_t;

	typedef struct packed {
		logic tx_done_flag;
		logic rx_done_flag;
	} flags_t;

	typedef struct packed {
		logic [7:0] data;
		logic       ninth;
		logic       stop;
	} rx_frame_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [3:0]        strb;
	} reg_wr_t;

endpackage

// >>> design/rx_frame_qualifier.sv
// decides whether a received frame is taken and what lands in the ninth bit
`timescale 1ns/100ps
module rx_frame_qualifier
	import uart_flag_pkg::*;
(
	input  wire uart_flag_pkg::ctrl_t     ctrl,
	input  wire logic                     rx_done_flag,
	input  wire uart_flag_pkg::rx_frame_t frame,
	input  wire logic [7:0]               port_addr,
	input  wire logic [7:0]               bcast_addr,
	output logic                          accept,
	output logic                          load_ninth,
	output logic                          ninth_val
);

	logic open_rx;
	logic addr_hit;

	// a pending byte blocks the next one so software never loses it unseen
	assign open_rx  = ctrl.rx_enable_bit & ~rx_done_flag;
	assign addr_hit = (frame.data == port_addr) | (frame.data == bcast_addr);

	always_comb begin
		accept     = 1'b0;
		load_ninth = 1'b0;
		ninth_val  = 1'b0;
		unique case (ctrl.mode)
			MODE_SYNC: begin
				accept = open_rx;
			end
			MODE_8BIT: begin
				accept     = open_rx & (~ctrl.multiproc_stop_check | frame.stop);
				load_ninth = 1'b1;
				ninth_val  = frame.stop;
			end
			MODE_9FIX, MODE_9VAR: begin
				accept     = open_rx & (~ctrl.multiproc_stop_check
					| (frame.ninth & addr_hit));
				load_ninth = 1'b1;
				ninth_val  = frame.ninth;
			end
		endcase
	end

endmodule

// >>> design/axil_slave.sv
// AXI4-Lite slave front end: one write and one read at a time
`timescale 1ns/100ps
module axil_slave
	import uart_flag_pkg::*;
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ADDR_W-1:0]         s_awaddr,
	input  wire logic                      s_awvalid,
	output logic                           s_awready,
	input  wire logic [DATA_W-1:0]         s_wdata,
	input  wire logic [3:0]                s_wstrb,
	input  wire logic                      s_wvalid,
	output logic                           s_wready,
	output logic [1:0]                     s_bresp,
	output logic                           s_bvalid,
	input  wire logic                      s_bready,
	input  wire logic [ADDR_W-1:0]         s_araddr,
	input  wire logic                      s_arvalid,
	output logic                           s_arready,
	output logic [DATA_W-1:0]              s_rdata,
	output logic [1:0]                     s_rresp,
	output logic                           s_rvalid,
	input  wire logic                      s_rready,
	output uart_flag_pkg::reg_wr_t         wr,
	output logic                           wr_fire,
	input  wire logic                      wr_ok,
	output logic [ADDR_W-1:0]              rd_addr,
	input  wire logic [DATA_W-1:0]         rd_word,
	input  wire logic                      rd_ok
);

	// address and data are each held until both have arrived
	assign wr_fire = ~s_awready & ~s_wready & ~s_bvalid;
	assign rd_addr = s_araddr;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= RESP_OKAY;
			wr        <= '0;
		end else begin
			if (s_awvalid && s_awready) begin
				s_awready <= 1'b0;
				wr.addr   <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				s_wready <= 1'b0;
				wr.data  <= s_wdata;
				wr.strb  <= s_wstrb;
			end
			if (wr_fire) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= '0;
			s_rresp   <= RESP_OKAY;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rdata   <= rd_word;
			s_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

endmodule

// >>> design/serial_flag_ctrl.sv
// control and completion flag logic of serial port zero
// Function
// - 8-bit mode, stop check 0: frame taken whatever the stop bit level.
// - 8-bit mode, stop check 1: receive flag set only if stop bit is one.
// - 9-bit modes, check 0: ninth bit plays no part in taking a frame.
// - 9-bit modes, check 1: flag only for ninth bit one and address match.
// - receive enable one takes frames; zero disables reception.
// - transmit ninth bit goes out as ninth bit in modes 2, 3 only.
// - modes 2 and 3: received ninth bit loads the receive ninth bit.
// - mode 1 with check 0: stop bit level loads the receive ninth bit.
// - synchronous mode 0 never updates the receive ninth bit.
// - transmit flag sets after eighth bit in mode 0, at stop start otherwise.
// - either flag raises the serial interrupt when enabled; only software clears.
// - receive flag sets when a byte is received and accepted.
`timescale 1ns/100ps
module serial_flag_ctrl
	import uart_flag_pkg::*;
(
	input  wire logic                      aclk,
	input  wire logic                      aresetn,
	input  wire logic [ADDR_W-1:0]         s_awaddr,
	input  wire logic                      s_awvalid,
	output logic                           s_awready,
	input  wire logic [DATA_W-1:0]         s_wdata,
	input  wire logic [3:0]                s_wstrb,
	input  wire logic                      s_wvalid,
	output logic                           s_wready,
	output logic [1:0]                     s_bresp,
	output logic                           s_bvalid,
	input  wire logic                      s_bready,
	input  wire logic [ADDR_W-1:0]         s_araddr,
	input  wire logic                      s_arvalid,
	output logic                           s_arready,
	output logic [DATA_W-1:0]              s_rdata,
	output logic [1:0]                     s_rresp,
	output logic                           s_rvalid,
	input  wire logic                      s_rready,
	input  wire logic                      rx_frame_valid,
	input  wire uart_flag_pkg::rx_frame_t  rx_frame,
	input  wire logic                      tx_eighth_done,
	input  wire logic                      tx_stop_begin,
	output uart_flag_pkg::serial_mode_t    serial_mode,
	output logic                           rx_enable_out,
	output logic                           tx_ninth_out,
	output logic                           rx_load,
	output logic [7:0]                     rx_byte,
	output logic                           irq
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	ctrl_t             ctrl;
	flags_t            flags;
	flags_t            mask;
	logic              rx_ninth_bit;
	logic [7:0]        port_addr;
	logic [7:0]        bcast_addr;

	reg_wr_t           wr;
	logic              wr_fire;
	logic              wr_ok;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_word;
	logic              rd_ok;

	logic              accept;
	logic              load_ninth;
	logic              ninth_val;
	logic              rx_take;
	logic              set_tx;
	flags_t            clr;

	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		reg_known = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_MASK)
			|| (a == OFF_RXDATA) || (a == OFF_ADDR);
	endfunction

	function automatic logic wr_hit(input reg_wr_t w, input logic [ADDR_W-1:0] a);
		wr_hit = (w.addr == a) && w.strb[0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// register bus

	axil_slave u_bus (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.s_awaddr  (s_awaddr),
		.s_awvalid (s_awvalid),
		.s_awready (s_awready),
		.s_wdata   (s_wdata),
		.s_wstrb   (s_wstrb),
		.s_wvalid  (s_wvalid),
		.s_wready  (s_wready),
		.s_bresp   (s_bresp),
		.s_bvalid  (s_bvalid),
		.s_bready  (s_bready),
		.s_araddr  (s_araddr),
		.s_arvalid (s_arvalid),
		.s_arready (s_arready),
		.s_rdata   (s_rdata),
		.s_rresp   (s_rresp),
		.s_rvalid  (s_rvalid),
		.s_rready  (s_rready),
		.wr        (wr),
		.wr_fire   (wr_fire),
		.wr_ok     (wr_ok),
		.rd_addr   (rd_addr),
		.rd_word   (rd_word),
		.rd_ok     (rd_ok)
	);

	assign wr_ok = reg_known(wr.addr);
	assign rd_ok = reg_known(rd_addr);

	always_comb begin
		rd_word = '0;
		unique case (rd_addr)
			OFF_CTRL: begin
				rd_word[CTRL_MSB:CTRL_LSB] = ctrl;
				rd_word[RX9_POS]           = rx_ninth_bit;
				rd_word[FLAG_MSB:0]        = flags;
			end
			OFF_STATUS: rd_word[FLAG_MSB:0] = flags;
			OFF_MASK:   rd_word[FLAG_MSB:0] = mask;
			OFF_RXDATA: rd_word[7:0]        = rx_byte;
			OFF_ADDR: begin
				rd_word[PORT_ADDR_LSB +: 8]  = port_addr;
				rd_word[BCAST_ADDR_LSB +: 8] = bcast_addr;
			end
			default:    rd_word = '0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// software-written control

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RST;
		end else if (wr_fire && wr_hit(wr, OFF_CTRL)) begin
			ctrl <= wr.data[CTRL_MSB:CTRL_LSB];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mask <= MASK_RST;
		end else if (wr_fire && wr_hit(wr, OFF_MASK)) begin
			mask <= wr.data[FLAG_MSB:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_addr  <= PORT_ADDR_RST;
			bcast_addr <= BCAST_ADDR_RST;
		end else if (wr_fire && wr.addr == OFF_ADDR) begin
			if (wr.strb[0]) begin
				port_addr <= wr.data[PORT_ADDR_LSB +: 8];
			end
			if (wr.strb[1]) begin
				bcast_addr <= wr.data[BCAST_ADDR_LSB +: 8];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive qualification

	rx_frame_qualifier u_qual (
		.ctrl         (ctrl),
		.rx_done_flag (flags.rx_done_flag),
		.frame        (rx_frame),
		.port_addr    (port_addr),
		.bcast_addr   (bcast_addr),
		.accept       (accept),
		.load_ninth   (load_ninth),
		.ninth_val    (ninth_val)
	);

	assign rx_take = rx_frame_valid & accept;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_byte <= 8'h00;
			rx_load <= 1'b0;
		end else begin
			rx_load <= rx_take;
			if (rx_take) begin
				rx_byte <= rx_frame.data;
			end
		end
	end

	// rejected frames leave the ninth bit alone as well as the data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_ninth_bit <= 1'b0;
		end else if (rx_take && load_ninth) begin
			rx_ninth_bit <= ninth_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// completion flags and interrupt

	// mode 0 has no stop bit; the async modes flag at its start
	assign set_tx = (ctrl.mode == MODE_SYNC) ? tx_eighth_done : tx_stop_begin;
	assign clr    = (wr_fire && wr_hit(wr, OFF_STATUS)) ? wr.data[FLAG_MSB:0] : '0;

	// a hardware set in the clearing cycle wins over the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
		end else begin
			flags.tx_done_flag <= set_tx | (flags.tx_done_flag & ~clr.tx_done_flag);
			flags.rx_done_flag <= rx_take | (flags.rx_done_flag & ~clr.rx_done_flag);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags & mask);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs to the shift engine

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			serial_mode   <= MODE_SYNC;
			rx_enable_out <= 1'b0;
			tx_ninth_out  <= 1'b0;
		end else begin
			serial_mode   <= ctrl.mode;
			rx_enable_out <= ctrl.rx_enable_bit;
			tx_ninth_out  <= ctrl.mode[1] & ctrl.tx_ninth_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	a_tx_sync_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode == MODE_SYNC && tx_eighth_done |=> flags.tx_done_flag)
		else $error("transmit flag missed after eighth bit");

	a_tx_async_set: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode != MODE_SYNC && tx_stop_begin |=> flags.tx_done_flag)
		else $error("transmit flag missed at stop start");

	a_tx_wrong_event: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode == MODE_SYNC && tx_stop_begin && !tx_eighth_done
		&& !flags.tx_done_flag |=> !flags.tx_done_flag)
		else $error("transmit flag set by stop event in mode 0");

	a_tx_async_eighth: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode != MODE_SYNC && tx_eighth_done && !tx_stop_begin
		&& !flags.tx_done_flag |=> !flags.tx_done_flag)
		else $error("transmit flag set by eighth bit outside mode 0");

	// only a software clear in this very cycle may drop a set flag
	a_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		flags.rx_done_flag && !clr.rx_done_flag |=> flags.rx_done_flag)
		else $error("receive flag cleared by hardware");

	a_tx_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		flags.tx_done_flag && !clr.tx_done_flag |=> flags.tx_done_flag)
		else $error("transmit flag cleared by hardware");

	a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		flags.tx_done_flag && mask.tx_done_flag |=> irq)
		else $error("interrupt not raised for masked-in flag");

	a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
		(mask & flags) == 2'h0 |=> !irq)
		else $error("interrupt raised with nothing enabled");

	a_rx_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_frame_valid && !ctrl.rx_enable_bit && !flags.rx_done_flag
		|=> !flags.rx_done_flag && !rx_load)
		else $error("frame taken while receive disabled");

	a_rx_held: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_frame_valid && flags.rx_done_flag |=> !rx_load)
		else $error("frame taken over a pending byte");

	a_stop_rejected: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode == MODE_8BIT && ctrl.multiproc_stop_check && rx_frame_valid
		&& !rx_frame.stop && !flags.rx_done_flag |=> !flags.rx_done_flag)
		else $error("frame with low stop bit taken");

	a_stop_accept: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode == MODE_8BIT && ctrl.multiproc_stop_check && ctrl.rx_enable_bit
		&& rx_frame_valid && rx_frame.stop && !flags.rx_done_flag
		|=> flags.rx_done_flag && rx_ninth_bit)
		else $error("frame with high stop bit not taken");

	a_stop_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode == MODE_8BIT && !ctrl.multiproc_stop_check && rx_frame_valid
		&& ctrl.rx_enable_bit && !flags.rx_done_flag
		|=> flags.rx_done_flag && rx_ninth_bit == $past(rx_frame.stop))
		else $error("8-bit frame not taken or stop bit not stored");

	a_addr_filter: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode[1] && ctrl.multiproc_stop_check && rx_frame_valid
		&& (!rx_frame.ninth || (rx_frame.data != port_addr
		&& rx_frame.data != bcast_addr)) && !flags.rx_done_flag
		|=> !flags.rx_done_flag)
		else $error("frame taken without address match");

	a_addr_accept: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode[1] && ctrl.multiproc_stop_check && ctrl.rx_enable_bit
		&& rx_frame_valid && rx_frame.ninth && (rx_frame.data == port_addr
		|| rx_frame.data == bcast_addr) && !flags.rx_done_flag
		|=> flags.rx_done_flag && rx_ninth_bit)
		else $error("addressed frame not taken");

	a_ninth_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode[1] && !ctrl.multiproc_stop_check && rx_frame_valid
		&& ctrl.rx_enable_bit && !flags.rx_done_flag
		|=> flags.rx_done_flag && rx_ninth_bit == $past(rx_frame.ninth))
		else $error("9-bit frame not taken or ninth bit not stored");

	a_sync_ninth: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl.mode == MODE_SYNC |=> $stable(rx_ninth_bit))
		else $error("ninth bit changed in mode 0");

	a_tx_ninth_out: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 tx_ninth_out == ($past(ctrl.mode[1]) && $past(ctrl.tx_ninth_bit)))
		else $error("ninth transmit bit wrong for mode");

	a_rx_load_data: assert property (@(posedge aclk) disable iff (!aresetn)
		rx_load |-> flags.rx_done_flag && rx_byte == $past(rx_frame.data))
		else $error("accepted byte not flagged or not stored");

	a_wr_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_fire |=> s_bvalid && !wr_fire)
		else $error("write answer not one cycle after both halves");

	a_rd_answer: assert property (@(posedge aclk) disable iff (!aresetn)
		s_arvalid && s_arready |=> s_rvalid && !s_arready)
		else $error("read answer not one cycle after address");

endmodule

// >>> sim/serial_node_model.sv
// far-side serial node as seen through the shift engine strobes
`timescale 1ns/100ps
module serial_node_model (
	input  wire logic                     aclk,
	output logic                          rx_frame_valid,
	output uart_flag_pkg::rx_frame_t      rx_frame,
	output logic                          tx_eighth_done,
	output logic                          tx_stop_begin
);
	import uart_flag_pkg::*;

	initial begin
		rx_frame_valid = 1'b0;
		rx_frame       = '0;
		tx_eighth_done = 1'b0;
		tx_stop_begin  = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// gap stands for a slow line: idle cycles before the frame completes
	task automatic send_frame(input logic [7:0] d, input logic n, input logic s, input int gap);
		repeat (gap + 1) @(posedge aclk);
		rx_frame_valid <= 1'b1;
		rx_frame       <= '{data: d, ninth: n, stop: s};
		@(posedge aclk);
		rx_frame_valid <= 1'b0;
		// no longer valid: show a changed pattern, never the stale frame
		rx_frame       <= ~rx_frame;
	endtask

	task automatic tx_event(input logic eighth);
		@(posedge aclk);
		tx_eighth_done <= eighth;
		tx_stop_begin  <= !eighth;
		@(posedge aclk);
		tx_eighth_done <= 1'b0;
		tx_stop_begin  <= 1'b0;
	endtask
endmodule

// >>> sim/serial_flag_ctrl_bench.sv
// self-checking bench for the serial port flag logic
`timescale 1ns/100ps
module serial_flag_ctrl_bench;
	import uart_flag_pkg::*;
	logic                aclk, aresetn;
	logic [ADDR_W-1:0]   s_awaddr, s_araddr;
	logic                s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic                s_arvalid, s_arready, s_rvalid, s_rready;
	logic [DATA_W-1:0]   s_wdata, s_rdata, rv;
	logic [3:0]          s_wstrb;
	logic [1:0]          s_bresp, s_rresp, rr;
	logic                rx_frame_valid, tx_eighth_done, tx_stop_begin;
	rx_frame_t           rx_frame;
	serial_mode_t        serial_mode;
	logic                rx_enable_out, tx_ninth_out, rx_load, irq;
	logic [7:0]          rx_byte;
	int                  err_count, checked, loads, seed, r, c, d, n, s, e;
	int                  m_mode, m_chk, m_ren, m_tx9, m_rx9, m_txf, m_rxf, m_byte;
	int                  m_mask, m_port, m_bcast, m_loads;

	serial_flag_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
		.s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
		.s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
		.s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
		.s_rready(s_rready), .rx_frame_valid(rx_frame_valid), .rx_frame(rx_frame),
		.tx_eighth_done(tx_eighth_done), .tx_stop_begin(tx_stop_begin),
		.serial_mode(serial_mode), .rx_enable_out(rx_enable_out),
		.tx_ninth_out(tx_ninth_out), .rx_load(rx_load), .rx_byte(rx_byte), .irq(irq));

	serial_node_model node (.aclk(aclk), .rx_frame_valid(rx_frame_valid),
		.rx_frame(rx_frame), .tx_eighth_done(tx_eighth_done), .tx_stop_begin(tx_stop_begin));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (aresetn === 1'b1 && rx_load === 1'b1) loads++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
		bit aw_done, w_done;
		aw_done = 0;
		w_done = 0;
		// start on an edge: callers may stand just past one after sampling
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= dat;
		s_wstrb <= 4'hf;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (aw_done && w_done && s_bvalid === 1'b1) begin
				resp = s_bresp;
				s_bready <= 1'b0;
				break;
			end
			if (!aw_done && s_awready === 1'b1) begin
				aw_done = 1;
				s_awvalid <= 1'b0;
			end
			if (!w_done && s_wready === 1'b1) begin
				w_done = 1;
				s_wvalid <= 1'b0;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
		bit ar_done;
		ar_done = 0;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (ar_done && s_rvalid === 1'b1) begin
				dat = s_rdata;
				resp = s_rresp;
				s_rready <= 1'b0;
				break;
			end
			if (!ar_done && s_arready === 1'b1) begin
				ar_done = 1;
				s_arvalid <= 1'b0;
			end
		end
	endtask

	task automatic settle(input int k);
		repeat (k) @(posedge aclk);
		#1;
	endtask

	function automatic logic [31:0] exp_ctrl();
		return 32'({2'(m_mode), 1'(m_chk), 1'(m_ren), 1'(m_tx9), 1'(m_rx9), 1'(m_txf),
			1'(m_rxf)});
	endfunction

	function automatic logic exp_irq();
		return ((2 * m_txf + m_rxf) & m_mask) != 0;
	endfunction

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// about 2000 cycles expected; twenty times that means a hang
	initial begin
		#(100 * 40000);
		err_count++;
		end_sim();
	end

	initial begin
		aresetn = 1'b0;
		{s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
		{m_mode, m_chk, m_ren, m_tx9, m_rx9, m_txf, m_rxf, m_byte, m_mask, m_loads} = '0;
		{m_port, m_bcast} = {32'd0, 32'd255};
		seed = $urandom(48);
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_CTRL, rv, rr);
		check(rv, exp_ctrl());
		rd(OFF_ADDR, rv, rr);
		check(rv, 32'h0000_ff00);
		rd(8'h14, rv, rr);
		check(rv, 32'h0000_0000);
		check(32'(rr), 32'(RESP_SLVERR));
		wr(8'h14, 32'h0000_00ff, rr);
		check(32'(rr), 32'(RESP_SLVERR));
		for (r = 0; r < 48; r++) begin
			{m_mode, m_chk, m_ren} = {r % 4, (r / 4) % 2, 32'((r / 8) % 2 | (r >= 16))};
			{m_tx9, m_mask} = {$urandom % 2, $urandom % 4};
			{m_port, m_bcast} = {$urandom % 256, $urandom % 256};
			wr(OFF_ADDR, 32'({8'(m_bcast), 8'(m_port)}), rr);
			wr(OFF_MASK, 32'(m_mask), rr);
			wr(OFF_CTRL, 32'({2'(m_mode), 1'(m_chk), 1'(m_ren), 1'(m_tx9), 3'h0}), rr);
			settle(1);
			check(32'({serial_mode, rx_enable_out}), 32'({2'(m_mode), 1'(m_ren)}));
			check(32'(tx_ninth_out), 32'(m_mode >= 2 && m_tx9 == 1));
			repeat (2) begin
				c = $urandom % 3;
				d = (c == 0) ? m_port : (c == 1) ? m_bcast : $urandom % 256;
				{n, s} = {$urandom % 2, $urandom % 2};
				node.send_frame(8'(d), 1'(n), 1'(s), $urandom % 3);
				// acceptance as the rx enable, holding flag and mode qualifier decide
				if (m_ren == 1 && m_rxf == 0 && (m_mode == 0 || (m_mode == 1 &&
					(m_chk == 0 || s == 1)) || (m_mode >= 2 && (m_chk == 0 ||
					(n == 1 && (d == m_port || d == m_bcast)))))) begin
					{m_rxf, m_byte} = {32'd1, d};
					m_loads++;
					if (m_mode == 1) m_rx9 = s;
					else if (m_mode >= 2) m_rx9 = n;
				end
				settle(3);
				check(32'(rx_byte), 32'(m_byte));
				check(32'(irq), 32'(exp_irq()));
			end
			e = $urandom % 2;
			node.tx_event(1'(e));
			if ((m_mode == 0) == (e == 1)) m_txf = 1;
			settle(2);
			check(32'(irq), 32'(exp_irq()));
			rd(OFF_CTRL, rv, rr);
			check(rv, exp_ctrl());
			check(32'(loads), 32'(m_loads));
			c = $urandom % 4;
			wr(OFF_STATUS, 32'(c), rr);
			{m_txf, m_rxf} = {m_txf & ~(c / 2), m_rxf & ~(c % 2)};
			rd(OFF_STATUS, rv, rr);
			check(rv, 32'({1'(m_txf), 1'(m_rxf)}));
			settle(1);
			check(32'(irq), 32'(exp_irq()));
		end
		wr(OFF_RXDATA, 32'($urandom), rr);
		rd(OFF_RXDATA, rv, rr);
		check(rv, 32'(m_byte));
		end_sim();
	end
endmodule
